// File: core/acq_ctrl_pkg.sv
// Purpose: shared constants and types for the acquisition control block
// Assumes: byte-wide register port, 25 MHz clock
// Notes:   offsets are byte addresses within the control region
package acq_ctrl_pkg;

   localparam int unsigned CLK_PERIOD_NS = 40;
   localparam int unsigned SKEW_NS       = 10000;
   localparam int unsigned SKEW_CYCLES   = (SKEW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [7:0]  SKEW_LOAD     = 8'(SKEW_CYCLES - 1);

   localparam int unsigned EDGE_W        = 5;
   localparam int unsigned CTR2_BIT      = 4;

   localparam logic [3:0] OFS_SCAN_LIMITS   = 4'h0;
   localparam logic [3:0] OFS_DIGITAL_LINES = 4'h1;
   localparam logic [3:0] OFS_CHAN_STATUS   = 4'h2;
   localparam logic [3:0] OFS_CONV_STATUS   = 4'h3;
   localparam logic [3:0] OFS_IRQ_CTRL      = 4'h4;
   localparam logic [3:0] OFS_PACER_CTRL    = 4'h5;
   localparam logic [3:0] OFS_BURST_CTRL    = 4'h6;
   localparam logic [3:0] OFS_RESID_LO      = 4'hd;
   localparam logic [3:0] OFS_RESID_HI      = 4'he;

   // field positions
   localparam int unsigned BIT_BUSY        = 7;
   localparam int unsigned BIT_IRQ_MASTER  = 7;
   localparam int unsigned BIT_IRQ_PENDING = 6;
   localparam int unsigned BIT_IRQ_ACQ     = 3;
   localparam int unsigned BIT_IRQ_OVERRUN = 4;
   localparam int unsigned BIT_ACQ_IRQ_ON  = 2;
   localparam int unsigned BIT_GATE_STATE  = 6;
   localparam int unsigned BIT_TRIGGER_POLARITY_SEL    = 5;
   localparam int unsigned BIT_GATE_LATCH  = 4;
   localparam int unsigned BIT_GATE_OVR    = 3;
   localparam int unsigned BIT_EXT_EDGE    = 2;
   localparam int unsigned BIT_BURST_ON    = 1;
   localparam int unsigned BIT_CONV_ALLOW  = 0;

   localparam logic [10:0] FIFO_HALF_LEVEL = 11'h200;
   localparam logic [9:0]  RESID_ONE       = 10'h001;
   localparam logic [9:0]  RESID_ZERO      = 10'h000;

   typedef enum logic [1:0] {
      IRQ_SRC_EOC   = 2'b00,
      IRQ_SRC_NEMPT = 2'b01,
      IRQ_SRC_EOB   = 2'b10,
      IRQ_SRC_HALF  = 2'b11
   } irq_src_type;

   typedef enum logic [1:0] {
      PACE_SW0 = 2'b00,
      PACE_SW1 = 2'b01,
      PACE_EXT = 2'b10,
      PACE_INT = 2'b11
   } pace_src_type;

   typedef enum logic [1:0] {
      SEQ_IDLE  = 2'b00,
      SEQ_START = 2'b01,
      SEQ_RUN   = 2'b10
   } seq_type;

endpackage

// File: core/din_edge.sv
// Purpose: registers input lines and flags their rising and falling edges
// Assumes: inputs synchronous to clk_i
// Notes:   one cycle edge pulses, masked to zero while en_i is low
`timescale 1ns/1ps
`default_nettype none
module din_edge
   import acq_ctrl_pkg::*;
(
   input  wire logic              clk_i,   // clock
   input  wire logic              nrst_i,  // sync reset, active low
   input  wire logic              en_i,    // clock enable
   input  wire logic [EDGE_W-1:0] line_i,  // lines to watch
   output logic      [EDGE_W-1:0] level_o, // registered level
   output logic      [EDGE_W-1:0] rise_o,  // rising edge pulse
   output logic      [EDGE_W-1:0] fall_o   // falling edge pulse
);
   typedef struct packed {
      logic [EDGE_W-1:0] cur;
      logic [EDGE_W-1:0] prev;
   } edge_state_type;

   edge_state_type r;
   edge_state_type next_r;

   always_comb begin
      next_r      = r;
      next_r.cur  = line_i;
      next_r.prev = r.cur;
   end

   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         r <= '0;
      end else if (en_i) begin
         r <= next_r;
      end
   end

   genvar g;
   generate
      for (g = 0; g < EDGE_W; g++) begin : g_edge
         assign level_o[g] = r.cur[g];
         assign rise_o[g]  = en_i & r.cur[g] & ~r.prev[g];
         assign fall_o[g]  = en_i & ~r.cur[g] & r.prev[g];
      end
   endgenerate
endmodule // din_edge
`default_nettype wire

// File: core/adc_acquisition_control.sv
// Purpose: register file, pacing, burst sequencing and interrupt logic
//          for a 16-channel sampling converter
// Assumes: byte register port synchronous to clk_i; converter raises
//          busy within one conversion skew of the start pulse
// Notes:   FIFO, pacer counters and converter are outside this block
`timescale 1ns/1ps
`default_nettype none
module adc_acquisition_control
   import acq_ctrl_pkg::*;
(
   input  wire logic        clk_i,          // 25 MHz clock
   input  wire logic        nrst_i,         // sync reset, active low
   input  wire logic        en_i,           // clock enable, freezes all state
   input  wire logic [3:0]  addr_i,         // register offset
   input  wire logic        wr_i,           // register write strobe
   input  wire logic        rd_i,           // register read strobe
   input  wire logic [7:0]  wdata_i,        // write data
   output logic      [7:0]  rdata_o,        // read data, next cycle
   input  wire logic [3:0]  din_i,          // digital input lines
   output logic      [3:0]  dout_o,         // latched digital outputs
   output logic             ctr_gate_o,     // counter gate from input 2
   input  wire logic        unipolar_sw_i,  // polarity switch, 1 unipolar
   input  wire logic        single_sw_i,    // mode switch, 1 single-ended
   input  wire logic        clk10_jmp_i,    // pacer jumper, 1 is 10 MHz
   input  wire logic        sw_convert_i,   // software convert pulse
   input  wire logic        ctr2_out_i,     // internal pacer counter output
   input  wire logic        conv_busy_i,    // converter busy
   output logic             conv_start_o,   // converter start pulse
   output logic      [3:0]  chan_o,         // current mux channel
   input  wire logic [10:0] fifo_count_i,   // samples held in fifo
   input  wire logic        fifo_write_i,   // sample written pulse
   input  wire logic        fifo_overrun_i, // fifo overrun pulse
   output logic             fifo_reset_o,   // fifo reset pulse
   output logic             pacer_gate_o,   // internal pacer gate open
   output logic             irq_o           // interrupt request
);
   typedef struct packed {
      logic [3:0]   dout;
      logic [3:0]   scan_lo;
      logic [3:0]   scan_hi;
      logic [3:0]   chan;
      logic         irq_master_on;
      logic         irq_pending;
      logic         acq_done_irq_on;
      irq_src_type  irq_source;
      pace_src_type pacing_src;
      logic         outside_pacing_edge;
      logic         gate_override;
      logic         gate_latch_mode;
      logic         trigger_polarity_sel;
      logic         gate_latched;
      logic         burst_on;
      logic         conversion_allow;
      logic         burst_done;
      logic         acquisition_done;
      logic         overrun;
      logic [9:0]   residual;
      logic [9:0]   resid_cnt;
      logic         busy_q;
      seq_type      seq;
      logic         last_chan;
      logic [7:0]   skew;
      logic         conv_start;
      logic         fifo_reset;
      logic [7:0]   rdata;
   } state_type;

   state_type r;
   state_type next_r;

   logic [EDGE_W-1:0] lvl;
   logic [EDGE_W-1:0] rise;
   logic [EDGE_W-1:0] fall;

   // input 0 and pacer counter edges
   din_edge u_edge (
      .clk_i   (clk_i),
      .nrst_i  (nrst_i),
      .en_i    (en_i),
      .line_i  ({ctr2_out_i, din_i}),
      .level_o (lvl),
      .rise_o  (rise),
      .fall_o  (fall)
   );

   logic       fifo_has_sample;
   logic       fifo_half_level;
   logic       gate_active_high;
   logic       gate_edge;
   logic       gate_open;
   logic       pace_evt;
   logic       eoc_evt;
   logic       eob_evt;
   logic       eoa_evt;
   logic       irq_req;
   logic [3:0] chan_step;
   logic       wr_hit;

   always_comb begin
      next_r            = r;
      next_r.conv_start = 1'b0;
      next_r.fifo_reset = 1'b0;
      next_r.busy_q     = conv_busy_i;
      eob_evt           = 1'b0;
      eoa_evt           = 1'b0;
      wr_hit            = wr_i & en_i;

      fifo_has_sample = (fifo_count_i != '0);
      fifo_half_level = (fifo_count_i >= FIFO_HALF_LEVEL);

      gate_active_high = ~(r.trigger_polarity_sel ^ r.burst_on);
      gate_edge        = gate_active_high ? rise[0] : fall[0];

      gate_open = r.gate_override |
                  (r.gate_latch_mode ? r.gate_latched : (lvl[0] == gate_active_high));
      if (!r.gate_override && r.gate_latch_mode && gate_edge) begin
         next_r.gate_latched = 1'b1;
      end

      case (r.pacing_src)
         PACE_EXT: pace_evt = r.outside_pacing_edge ? fall[0] : rise[0];
         PACE_INT: pace_evt = rise[CTR2_BIT] & gate_open;
         default:  pace_evt = sw_convert_i;
      endcase
      pace_evt = pace_evt & r.conversion_allow & en_i;

      chan_step = (r.chan == r.scan_hi) ? r.scan_lo : r.chan + 4'h1;

      eoc_evt = r.busy_q & ~conv_busy_i;

      // conversion sequencer
      case (r.seq)
         SEQ_IDLE: begin
            if (pace_evt) begin
               next_r.seq = SEQ_START;
               if (r.burst_on) begin
                  next_r.burst_done = 1'b0;
               end
            end
         end
         SEQ_START: begin
            next_r.conv_start = 1'b1;
            next_r.last_chan  = (r.chan == r.scan_hi);
            next_r.skew       = SKEW_LOAD;
            next_r.seq        = SEQ_RUN;
         end
         SEQ_RUN: begin
            if (r.conv_start) begin
               next_r.chan = chan_step;
            end
            if (r.skew != '0) begin
               next_r.skew = r.skew - 8'h01;
            end else if (!conv_busy_i && !r.conv_start) begin
               if (r.burst_on && !r.last_chan && r.conversion_allow) begin
                  next_r.seq = SEQ_START;
               end else begin
                  next_r.seq = SEQ_IDLE;
                  if (r.burst_on) begin
                     next_r.burst_done = 1'b1;
                     eob_evt           = 1'b1;
                  end
               end
            end
         end
         default: next_r.seq = SEQ_IDLE;
      endcase

      if (r.acq_done_irq_on && fifo_write_i && r.resid_cnt != RESID_ZERO) begin
         next_r.resid_cnt = r.resid_cnt - RESID_ONE;
         if (r.resid_cnt == RESID_ONE) begin
            eoa_evt = 1'b1;
         end
      end

      case (r.irq_source)
         IRQ_SRC_EOC:   irq_req = eoc_evt;
         IRQ_SRC_NEMPT: irq_req = fifo_has_sample;
         IRQ_SRC_EOB:   irq_req = eob_evt;
         default:       irq_req = fifo_half_level;
      endcase
      irq_req = (irq_req | (eoa_evt & r.acq_done_irq_on)) & r.irq_master_on & en_i;

      // register writes
      if (wr_hit) begin
         case (addr_i)
            OFS_SCAN_LIMITS: begin
               next_r.scan_lo    = wdata_i[3:0];
               next_r.scan_hi    = wdata_i[7:4];
               next_r.chan       = wdata_i[3:0];
               next_r.fifo_reset = 1'b1;
               next_r.overrun    = 1'b0;
            end
            OFS_DIGITAL_LINES: next_r.dout = wdata_i[3:0];
            OFS_IRQ_CTRL: begin
               next_r.irq_master_on   = wdata_i[BIT_IRQ_MASTER];
               next_r.acq_done_irq_on = wdata_i[BIT_ACQ_IRQ_ON];
               next_r.irq_source      = irq_src_type'(wdata_i[1:0]);
               if (!wdata_i[BIT_IRQ_PENDING]) begin
                  next_r.irq_pending      = 1'b0;
                  next_r.acquisition_done = 1'b0;
               end
            end
            OFS_PACER_CTRL: begin
               next_r.pacing_src           = pace_src_type'(wdata_i[1:0]);
               next_r.outside_pacing_edge  = wdata_i[BIT_EXT_EDGE];
               next_r.gate_override        = wdata_i[BIT_GATE_OVR];
               next_r.gate_latch_mode      = wdata_i[BIT_GATE_LATCH];
               next_r.trigger_polarity_sel = wdata_i[BIT_TRIGGER_POLARITY_SEL];
               if (!wdata_i[BIT_GATE_STATE]) begin
                  next_r.gate_latched = 1'b0;
               end
            end
            OFS_BURST_CTRL: begin
               next_r.burst_on         = wdata_i[BIT_BURST_ON];
               next_r.conversion_allow = wdata_i[BIT_CONV_ALLOW];
            end
            OFS_RESID_LO: begin
               next_r.residual[7:0] = wdata_i;
               next_r.resid_cnt     = {r.residual[9:8], wdata_i};
            end
            OFS_RESID_HI: begin
               next_r.residual[9:8] = wdata_i[1:0];
               next_r.resid_cnt     = {wdata_i[1:0], r.residual[7:0]};
            end
            default: ;
         endcase
      end

      // hardware sets win over software clears
      // edge during clear still latches
      if (!r.gate_override && r.gate_latch_mode && gate_edge) begin
         next_r.gate_latched = 1'b1;
      end
      if (eoa_evt) begin
         next_r.acquisition_done = 1'b1;
      end
      if (fifo_overrun_i) begin
         next_r.overrun = 1'b1;
      end
      if (irq_req) begin
         next_r.irq_pending = 1'b1;
      end

      // register reads
      if (rd_i) begin
         case (addr_i)
            OFS_SCAN_LIMITS:   next_r.rdata = {r.scan_hi, r.scan_lo};
            OFS_DIGITAL_LINES: next_r.rdata = {4'h0, din_i};
            OFS_CHAN_STATUS:   next_r.rdata = {conv_busy_i, unipolar_sw_i, single_sw_i,
                                               clk10_jmp_i, r.chan};
            OFS_CONV_STATUS:   next_r.rdata = {conv_busy_i, r.burst_done,
                                               r.acquisition_done, fifo_has_sample,
                                               fifo_half_level, r.overrun, 2'b00};
            OFS_IRQ_CTRL:      next_r.rdata = {r.irq_master_on, r.irq_pending, 1'b0,
                                               r.overrun, r.acquisition_done,
                                               r.acq_done_irq_on, r.irq_source};
            OFS_PACER_CTRL:    next_r.rdata = {1'b0, gate_open, r.trigger_polarity_sel,
                                               r.gate_latch_mode, r.gate_override,
                                               r.outside_pacing_edge, r.pacing_src};
            OFS_BURST_CTRL:    next_r.rdata = {6'h00, r.burst_on, r.conversion_allow};
            default:           next_r.rdata = 8'h00;
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         r <= '0;
      end else if (en_i) begin
         r <= next_r;
      end
   end

   assign rdata_o      = r.rdata;
   assign dout_o       = r.dout;
   // input 2 doubles as counter gate
   assign ctr_gate_o   = din_i[2];
   assign conv_start_o = r.conv_start;
   assign chan_o       = r.chan;
   assign fifo_reset_o = r.fifo_reset;
   assign pacer_gate_o = gate_open;
   assign irq_o        = r.irq_pending & r.irq_master_on;
endmodule // adc_acquisition_control
`default_nettype wire

// File: verification/acq_ctrl_sva.sv
// Purpose: port-level checks of the acquisition control block
// Assumes: en_i high whenever a check's cause is sampled
// Notes:   switch bits are compared on every read, the channel only while the converter is idle, other reads only while their source is steady
`timescale 1ns/1ps
`default_nettype none
module acq_ctrl_sva
   import acq_ctrl_pkg::*;
(
   input wire logic        clk_i,          // clock
   input wire logic        nrst_i,         // reset
   input wire logic        en_i,           // enable
   input wire logic [3:0]  addr_i,         // offset
   input wire logic        wr_i,           // write
   input wire logic        rd_i,           // read
   input wire logic [7:0]  wdata_i,        // write data
   input wire logic [7:0]  rdata_o,        // read data
   input wire logic [3:0]  din_i,          // inputs
   input wire logic [3:0]  dout_o,         // outputs
   input wire logic        ctr_gate_o,     // counter gate
   input wire logic        unipolar_sw_i,  // switch
   input wire logic        single_sw_i,    // switch
   input wire logic        clk10_jmp_i,    // jumper
   input wire logic        conv_busy_i,    // busy
   input wire logic        conv_start_o,   // start
   input wire logic [3:0]  chan_o,         // channel
   input wire logic [10:0] fifo_count_i,   // fifo level
   input wire logic        fifo_reset_o,   // fifo reset
   input wire logic        irq_o           // interrupt
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!nrst_i);

   // cycles since the last start pulse, saturating
   logic [8:0] gap;
   always_ff @(posedge clk_i) begin
      if (!nrst_i)
         gap <= 9'h1ff;
      else if (en_i && conv_start_o)
         gap <= 9'h000;
      else if (en_i && gap != 9'h1ff)
         gap <= gap + 9'h001;
   end

   AST_DIN_READ: assert property (en_i && rd_i && addr_i == OFS_DIGITAL_LINES && $stable(din_i)
      |=> rdata_o == {4'h0, $past(din_i)}) else $error("digital read wrong");
   AST_DOUT_LATCH: assert property (en_i && wr_i && addr_i == OFS_DIGITAL_LINES
      |=> {4'h0, dout_o} == ($past(wdata_i) & 8'h0f)) else $error("outputs not latched");
   AST_CTR_GATE: assert property (ctr_gate_o == din_i[2]) else $error("counter gate wrong");
   AST_BUSY_MIRROR: assert property (en_i && rd_i && $stable(conv_busy_i)
      && (addr_i == OFS_CHAN_STATUS || addr_i == OFS_CONV_STATUS)
      |=> rdata_o[7] == $past(conv_busy_i)) else $error("busy bit wrong");
   AST_SWITCHES: assert property (en_i && rd_i && addr_i == OFS_CHAN_STATUS
      |=> rdata_o[6] == $past(unipolar_sw_i) && rdata_o[5] == $past(single_sw_i)
      && rdata_o[4] == $past(clk10_jmp_i)) else $error("switch bits wrong");
   AST_CHAN_READ: assert property (en_i && rd_i && addr_i == OFS_CHAN_STATUS
      && !conv_busy_i && !conv_start_o |=> rdata_o[3:0] == $past(chan_o))
      else $error("channel read wrong");
   AST_FIFO_FLAGS: assert property (en_i && rd_i && addr_i == OFS_CONV_STATUS
      && $stable(fifo_count_i) |=> rdata_o[4] == ($past(fifo_count_i) != 11'h000)
      && rdata_o[3] == ($past(fifo_count_i) >= FIFO_HALF_LEVEL)) else $error("fifo flags wrong");
   AST_IRQ_MASTER_OFF: assert property (en_i && wr_i && addr_i == OFS_IRQ_CTRL
      && !wdata_i[7] |=> !irq_o) else $error("irq with master off");
   AST_START_GAP: assert property (conv_start_o |-> gap >= 9'h0f9)
      else $error("starts too close");
   AST_SCAN_LOAD: assert property (en_i && wr_i && addr_i == OFS_SCAN_LIMITS
      |=> fifo_reset_o && {4'h0, chan_o} == ($past(wdata_i) & 8'h0f) ##1 !fifo_reset_o)
      else $error("scan write effect wrong");
endmodule // acq_ctrl_sva

bind adc_acquisition_control acq_ctrl_sva i_acq_ctrl_sva (.clk_i(clk_i), .nrst_i(nrst_i),
   .en_i(en_i), .addr_i(addr_i), .wr_i(wr_i), .rd_i(rd_i), .wdata_i(wdata_i),
   .rdata_o(rdata_o), .din_i(din_i), .dout_o(dout_o), .ctr_gate_o(ctr_gate_o),
   .unipolar_sw_i(unipolar_sw_i), .single_sw_i(single_sw_i), .clk10_jmp_i(clk10_jmp_i),
   .conv_busy_i(conv_busy_i), .conv_start_o(conv_start_o), .chan_o(chan_o),
   .fifo_count_i(fifo_count_i), .fifo_reset_o(fifo_reset_o), .irq_o(irq_o));
`default_nettype wire

// File: verification/conv_model.sv
// Purpose: converter and sample fifo stand-in
// Assumes: start pulse one cycle long
// Notes:   busy 60 cycles, one sample written as busy ends
`timescale 1ns/1ps
`default_nettype none
module conv_model (
   input  wire logic        clk_i,   // clock
   input  wire logic        start_i, // conversion start
   input  wire logic        clr_i,   // fifo reset
   input  wire logic        ovr_i,   // inject overrun
   input  wire logic        load_i,  // preset fifo level
   input  wire logic [10:0] level_i, // preset value
   output logic             busy_o,  // converter busy
   output logic             wr_o,    // sample written
   output logic             ovr_o,   // overrun pulse
   output logic      [10:0] count_o  // fifo level
);
   int cnt = 0;
   initial begin
      busy_o = 1'b0;
      wr_o = 1'b0;
      ovr_o = 1'b0;
      count_o = 11'h000;
   end
   always @(posedge clk_i) begin
      wr_o <= 1'b0;
      ovr_o <= ovr_i;
      if (start_i) begin
         busy_o <= 1'b1;
         cnt <= 60;
      end else if (cnt > 1)
         cnt <= cnt - 1;
      else if (busy_o) begin
         busy_o <= 1'b0;
         wr_o <= 1'b1;
         count_o <= count_o + 11'h001;
      end
      if (clr_i)
         count_o <= 11'h000;
      else if (load_i)
         count_o <= level_i;
   end
endmodule // conv_model
`default_nettype wire

// File: verification/testbench.sv
// Purpose: self-checking bench for the acquisition control block
// Assumes: scan write resets the stand-in fifo
// Notes:   reads are sampled one edge after the data lands
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import acq_ctrl_pkg::*;
   logic clk_i = 1'b0, nrst_i = 1'b0, en_i = 1'b1, wr_i = 1'b0, rd_i = 1'b0;
   logic [3:0] addr_i = 4'h0, din_i = 4'h0, dout_o, chan_o;
   logic [7:0] wdata_i = 8'h00, rdata_o;
   logic unipolar_sw_i = 1'b1, single_sw_i = 1'b0, clk10_jmp_i = 1'b1;
   logic sw_convert_i = 1'b0, ctr2_out_i = 1'b0, conv_busy_i, conv_start_o, ctr_gate_o;
   logic fifo_write_i, fifo_overrun_i, fifo_reset_o, pacer_gate_o, irq_o, s;
   logic ovr_req = 1'b0, load = 1'b0;
   logic [10:0] fifo_count_i, level = 11'h000;
   int error_cnt = 0, n_tests = 0;

   adc_acquisition_control i_adc_acquisition_control (.clk_i(clk_i), .nrst_i(nrst_i),
      .en_i(en_i), .addr_i(addr_i), .wr_i(wr_i), .rd_i(rd_i), .wdata_i(wdata_i),
      .rdata_o(rdata_o), .din_i(din_i), .dout_o(dout_o), .ctr_gate_o(ctr_gate_o),
      .unipolar_sw_i(unipolar_sw_i), .single_sw_i(single_sw_i), .clk10_jmp_i(clk10_jmp_i),
      .sw_convert_i(sw_convert_i), .ctr2_out_i(ctr2_out_i), .conv_busy_i(conv_busy_i),
      .conv_start_o(conv_start_o), .chan_o(chan_o), .fifo_count_i(fifo_count_i),
      .fifo_write_i(fifo_write_i), .fifo_overrun_i(fifo_overrun_i),
      .fifo_reset_o(fifo_reset_o), .pacer_gate_o(pacer_gate_o), .irq_o(irq_o));
   conv_model i_conv_model (.clk_i(clk_i), .start_i(conv_start_o), .clr_i(fifo_reset_o),
      .ovr_i(ovr_req), .load_i(load), .level_i(level), .busy_o(conv_busy_i),
      .wr_o(fifo_write_i), .ovr_o(fifo_overrun_i), .count_o(fifo_count_i));

   initial forever #20 clk_i = ~clk_i;

   task automatic chk(input string nm, input logic [7:0] ex, input logic [7:0] got);
      n_tests++;
      if (got !== ex) begin
         error_cnt++;
         $display("[ERR] %s expected %h seen %h", nm, ex, got);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk_i);
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk_i);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
      @(posedge clk_i);
      wr_i <= 1'b0;
   endtask
   // read, mask and compare
   task automatic rck(input string nm, input logic [3:0] a, input logic [7:0] m,
                      input logic [7:0] ex);
      @(posedge clk_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge clk_i);
      rd_i <= 1'b0;
      @(posedge clk_i);
      chk(nm, ex, rdata_o & m);
   endtask
   task automatic sw();
      @(posedge clk_i);
      sw_convert_i <= 1'b1;
      @(posedge clk_i);
      sw_convert_i <= 1'b0;
   endtask
   task automatic ws(input int lim, output logic seen);
      seen = 1'b0;
      repeat (lim) begin
         @(posedge clk_i);
         if (conv_start_o === 1'b1) begin
            seen = 1'b1;
            break;
         end
      end
   endtask
   task automatic test_done();
      $display("checks %0d mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   task automatic t_digital();
      din_i <= 4'hd;
      wr(OFS_DIGITAL_LINES, 8'ha5);
      tick(1);
      chk("dout", 8'h05, 8'(dout_o));
      rck("din", OFS_DIGITAL_LINES, 8'hff, 8'h0d);
      chk("ctr_gate", 8'h01, 8'(ctr_gate_o));
      $display("t_digital done");
   endtask
   task automatic t_status();
      wr(OFS_SCAN_LIMITS, 8'h52);
      tick(1);
      chk("fifo_reset", 8'h01, 8'(fifo_reset_o));
      chk("chan", 8'h02, 8'(chan_o));
      tick(1);
      chk("fifo_reset_end", 8'h00, 8'(fifo_reset_o));
      rck("chan_status", OFS_CHAN_STATUS, 8'hff, 8'h52);
      rck("scan_limits", OFS_SCAN_LIMITS, 8'hff, 8'h52);
      $display("t_status done");
   endtask
   task automatic t_soft();
      wr(OFS_PACER_CTRL, 8'h00);
      sw();
      ws(10, s);
      chk("start_disabled", 8'h00, 8'(s));
      wr(OFS_BURST_CTRL, 8'h01);
      wr(OFS_IRQ_CTRL, 8'h80);
      sw();
      ws(10, s);
      chk("start_sw", 8'h01, 8'(s));
      tick(2);
      chk("chan_step", 8'h03, 8'(chan_o));
      rck("busy", OFS_CONV_STATUS, 8'h80, 8'h80);
      tick(100);
      chk("irq_eoc", 8'h01, 8'(irq_o));
      rck("pending", OFS_IRQ_CTRL, 8'hc3, 8'hc0);
      wr(OFS_IRQ_CTRL, 8'h80);
      tick(1);
      chk("irq_clear", 8'h00, 8'(irq_o));
      tick(300);
      $display("t_soft done");
   endtask
   task automatic t_burst();
      wr(OFS_IRQ_CTRL, 8'h82);
      wr(OFS_SCAN_LIMITS, 8'h31);
      wr(OFS_BURST_CTRL, 8'h03);
      rck("burst_idle", OFS_CONV_STATUS, 8'h40, 8'h00);
      sw();
      for (int i = 0; i < 3; i++) begin
         ws(400, s);
         chk("burst_start", 8'h01, 8'(s));
         chk("burst_chan", 8'(i + 1), 8'(chan_o));
      end
      ws(400, s);
      chk("burst_extra", 8'h00, 8'(s));
      chk("burst_wrap", 8'h01, 8'(chan_o));
      rck("burst_done", OFS_CONV_STATUS, 8'h40, 8'h40);
      chk("irq_eob", 8'h01, 8'(irq_o));
      $display("t_burst done");
   endtask
   task automatic t_ext();
      din_i <= 4'h0;
      wr(OFS_BURST_CTRL, 8'h01);
      wr(OFS_PACER_CTRL, 8'h02);
      din_i <= 4'h1;
      ws(10, s);
      chk("ext_rise", 8'h01, 8'(s));
      tick(300);
      wr(OFS_PACER_CTRL, 8'h06);
      din_i <= 4'h0;
      ws(10, s);
      chk("ext_fall", 8'h01, 8'(s));
      tick(300);
      din_i <= 4'h1;
      ws(10, s);
      chk("ext_rise_off", 8'h00, 8'(s));
      $display("t_ext done");
   endtask
   task automatic t_gate();
      wr(OFS_PACER_CTRL, 8'h0b);
      din_i <= 4'h0;
      tick(1);
      chk("gate_override", 8'h01, 8'(pacer_gate_o));
      rck("gate_state", OFS_PACER_CTRL, 8'h40, 8'h40);
      ctr2_out_i <= 1'b1;
      ws(10, s);
      ctr2_out_i <= 1'b0;
      chk("int_pacer", 8'h01, 8'(s));
      tick(300);
      wr(OFS_PACER_CTRL, 8'h03);
      tick(3);
      chk("gate_low", 8'h00, 8'(pacer_gate_o));
      din_i <= 4'h1;
      tick(3);
      chk("gate_high", 8'h01, 8'(pacer_gate_o));
      wr(OFS_PACER_CTRL, 8'h23);
      tick(1);
      chk("trigger_polarity_sel", 8'h00, 8'(pacer_gate_o));
      din_i <= 4'h0;
      wr(OFS_PACER_CTRL, 8'h13);
      din_i <= 4'h1;
      tick(3);
      din_i <= 4'h0;
      tick(3);
      chk("gate_latched", 8'h01, 8'(pacer_gate_o));
      wr(OFS_PACER_CTRL, 8'h13);
      tick(1);
      chk("gate_unlatched", 8'h00, 8'(pacer_gate_o));
      $display("t_gate done");
   endtask
   task automatic t_levels();
      logic [1:0] src[2] = '{2'b01, 2'b11};
      logic [10:0] lo[2] = '{11'h000, 11'h1ff};
      logic [10:0] hi[2] = '{11'h001, 11'h200};
      logic [7:0] fhi[2] = '{8'h10, 8'h18};
      wr(OFS_BURST_CTRL, 8'h00);
      for (int i = 0; i < 2; i++) begin
         level <= lo[i];
         load <= 1'b1;
         wr(OFS_IRQ_CTRL, {6'h20, src[i]});
         load <= 1'b0;
         tick(2);
         chk("irq_below", 8'h00, 8'(irq_o));
         rck("flags_below", OFS_CONV_STATUS, 8'h18, {3'h0, i[0], 4'h0});
         level <= hi[i];
         load <= 1'b1;
         tick(1);
         load <= 1'b0;
         tick(2);
         chk("irq_level", 8'h01, 8'(irq_o));
         rck("flags_at", OFS_CONV_STATUS, 8'h18, fhi[i]);
         wr(OFS_IRQ_CTRL, {6'h00, src[i]});
         tick(2);
         chk("irq_master_off", 8'h00, 8'(irq_o));
      end
      $display("t_levels done");
   endtask
   task automatic t_resid();
      wr(OFS_SCAN_LIMITS, 8'h20);
      wr(OFS_RESID_LO, 8'h02);
      wr(OFS_RESID_HI, 8'h00);
      wr(OFS_IRQ_CTRL, 8'h86);
      wr(OFS_PACER_CTRL, 8'h00);
      wr(OFS_BURST_CTRL, 8'h01);
      sw();
      tick(300);
      chk("acq_early", 8'h00, 8'(irq_o));
      rck("acq_flag_early", OFS_CONV_STATUS, 8'h20, 8'h00);
      sw();
      tick(300);
      chk("acq_irq", 8'h01, 8'(irq_o));
      rck("acq_flag", OFS_CONV_STATUS, 8'h20, 8'h20);
      rck("acq_irq_reg", OFS_IRQ_CTRL, 8'h48, 8'h48);
      wr(OFS_IRQ_CTRL, 8'h86);
      tick(1);
      chk("acq_irq_clear", 8'h00, 8'(irq_o));
      rck("acq_cleared", OFS_CONV_STATUS, 8'h20, 8'h00);
      ovr_req <= 1'b1;
      tick(1);
      ovr_req <= 1'b0;
      tick(3);
      rck("overrun_conv", OFS_CONV_STATUS, 8'h04, 8'h04);
      rck("overrun_irq", OFS_IRQ_CTRL, 8'h10, 8'h10);
      $display("t_resid done");
   endtask

   initial begin
      #(40 * 20000);
      error_cnt++;
      test_done();
   end
   initial begin
      tick(10);
      nrst_i <= 1'b1;
      t_digital();
      t_status();
      t_soft();
      t_burst();
      t_ext();
      t_gate();
      t_levels();
      t_resid();
      test_done();
   end
endmodule // testbench
`default_nettype wire
